// >>> core/sbrl_map.vh
`ifndef SBRL_MAP_VH
`define SBRL_MAP_VH
// ----------------------------------------------------------------
// session byte values
// ----------------------------------------------------------------
`define SBRL_SYNC 8'h86
`define SBRL_CMD_LOAD 8'h10
`define SBRL_CMD_SUM 8'h20
`define SBRL_CMD_INFO 8'h30
`define SBRL_CMD_ERASE 8'h40
`define SBRL_CMD_PROT 8'h60
// ----------------------------------------------------------------
// acknowledge low nibbles
// ----------------------------------------------------------------
`define SBRL_NIB_OK 4'h0
`define SBRL_NIB_BAD 4'h1
`define SBRL_NIB_PROT 4'h6
`define SBRL_NIB_COMM 4'h8
// ----------------------------------------------------------------
// field lengths and checksum target
// ----------------------------------------------------------------
`define SBRL_PWD_LAST 4'hB
`define SBRL_HDR_LAST 4'h5
`define SBRL_SUM_OK 8'h00
// ----------------------------------------------------------------
// user ram window
// ----------------------------------------------------------------
`define SBRL_RAM_BASE 32'h00001000
`define SBRL_RAM_END 32'h00002DFF
`define SBRL_RAM_DEPTH 7680
`define SBRL_RAM_AW 13
// ----------------------------------------------------------------
// baud measurement limits: minimum in clock cycles per bit, maximum in cycles of the two-bit low time
// ----------------------------------------------------------------
`define SBRL_BIT_MIN 16'h0010
`define SBRL_MEAS_MAX 17'h1FFFF
`endif

// >>> core/sbrl_ram.v
`timescale 1ns/1ps
`include "sbrl_map.vh"
// ----------------------------------------------------------------
// user ram: one write port, one registered read port
// ----------------------------------------------------------------
module sbrl_ram (
  input wire clk,
  input wire we,
  input wire [`SBRL_RAM_AW-1:0] waddr,
  input wire [7:0] wdata,
  input wire [`SBRL_RAM_AW-1:0] raddr,
  output reg [7:0] rdata
);
  // storage; no reset, contents are undefined until loaded
  reg [7:0] mem [0:`SBRL_RAM_DEPTH-1];

  // write and registered read
  always @(posedge clk)
  begin
    if (we)
    begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // sbrl_ram

// >>> core/sbrl_loader.v
`timescale 1ns/1ps
`include "sbrl_map.vh"
module sbrl_loader (
  input wire CLK_SYS,
  input wire RST,
  input wire RXD,
  output reg TXD,
  input wire RD_PROT_STRAP,
  input wire WR_PROT_STRAP,
  output reg [3:0] FLASH_PWD_IDX,
  input wire [7:0] FLASH_PWD_DATA,
  input wire PGM_RD_REQ,
  input wire PGM_WR_REQ,
  output reg PGM_RD_GRANT,
  output reg PGM_WR_GRANT,
  output reg ERASE_ALL,
  output reg RD_PROT,
  output reg WR_PROT,
  output reg [15:0] BAUD_DIVIDER_CONTROL,
  output reg BAUD_FRACTION_ADJUST,
  output reg RECEIVER_ENABLE_BIT,
  output reg HALTED,
  output reg JUMP,
  output reg [31:0] JUMP_ADDR,
  input wire [`SBRL_RAM_AW-1:0] CPU_RD_ADDR,
  output wire [7:0] CPU_RD_DATA
);
  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  localparam [3:0] ST_SYNC = 4'h0;
  localparam [3:0] ST_MEAS = 4'h1;
  localparam [3:0] ST_QUIET = 4'h2;
  localparam [3:0] ST_ACKS = 4'h3;
  localparam [3:0] ST_CMD = 4'h4;
  localparam [3:0] ST_PWD = 4'h5;
  localparam [3:0] ST_PCHK = 4'h6;
  localparam [3:0] ST_HDR = 4'h7;
  localparam [3:0] ST_HCHK = 4'h8;
  localparam [3:0] ST_DATA = 4'h9;
  localparam [3:0] ST_DCHK = 4'hA;
  localparam [3:0] ST_RUN = 4'hB;
  localparam [3:0] ST_HALT = 4'hC;

  // ----------------------------------------------------------------
  // functions
  // ----------------------------------------------------------------
  // one bit time less one; the fraction stretches every other bit
  function [15:0] bit_len;
    input [15:0] d;
    input f;
    input ph;
    begin
      bit_len = d + {15'h0000, f & ph} - 16'h0001;
    end
  endfunction

  // acknowledge byte from the kept upper nibble and a low nibble
  function [7:0] ack_of;
    input [3:0] hi;
    input [3:0] lo;
    begin
      ack_of = {hi, lo};
    end
  endfunction

  // ----------------------------------------------------------------
  // line sampling and receiver
  // ----------------------------------------------------------------
  reg rxd_q; // sampled line
  reg rxd_p; // previous sample, for edge finding
  reg [1:0] rx_ph; // 0 idle, 1 start, 2 data, 3 stop
  reg [15:0] rx_cnt; // cycles left in this bit
  reg [2:0] rx_bit; // data bit index
  reg [7:0] rx_sh; // shift register, lsb first
  reg rx_tog; // fraction phase
  reg rx_done; // one-cycle byte strobe
  reg [7:0] rx_byte; // received byte
  reg rx_ferr; // stop bit was low
  wire rx_fall = rxd_p & ~rxd_q;

  // 8N1 receiver, centred sampling, runs only while enabled
  always @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      rxd_q <= 1'b1;
      rxd_p <= 1'b1;
      rx_ph <= 2'b00;
      rx_cnt <= 16'h0000;
      rx_bit <= 3'h0;
      rx_sh <= 8'h00;
      rx_tog <= 1'b0;
      rx_done <= 1'b0;
      rx_byte <= 8'h00;
      rx_ferr <= 1'b0;
    end
    else
    begin
      rxd_q <= RXD;
      rxd_p <= rxd_q;
      rx_done <= 1'b0;
      case (rx_ph)
        2'b00:
        begin
          // half a bit to the start bit centre
          if (RECEIVER_ENABLE_BIT && rx_fall)
          begin
            rx_ph <= 2'b01;
            rx_cnt <= {1'b0, BAUD_DIVIDER_CONTROL[15:1]};
            rx_tog <= 1'b0;
          end
        end
        2'b01:
        begin
          if (rx_cnt != 16'h0000)
            rx_cnt <= rx_cnt - 16'h0001;
          else if (!rxd_q)
          begin
            rx_ph <= 2'b10;
            rx_bit <= 3'h0;
            rx_cnt <= bit_len(BAUD_DIVIDER_CONTROL, BAUD_FRACTION_ADJUST, rx_tog);
          end
          else
            rx_ph <= 2'b00; // glitch, not a start bit
        end
        2'b10:
        begin
          if (rx_cnt != 16'h0000)
            rx_cnt <= rx_cnt - 16'h0001;
          else
          begin
            rx_sh <= {rxd_q, rx_sh[7:1]};
            rx_tog <= ~rx_tog;
            rx_cnt <= bit_len(BAUD_DIVIDER_CONTROL, BAUD_FRACTION_ADJUST, ~rx_tog);
            if (rx_bit == 3'h7)
              rx_ph <= 2'b11;
            else
              rx_bit <= rx_bit + 3'h1;
          end
        end
        default:
        begin
          // byte reported at the stop bit centre
          if (rx_cnt != 16'h0000)
            rx_cnt <= rx_cnt - 16'h0001;
          else
          begin
            rx_done <= 1'b1;
            rx_byte <= rx_sh;
            rx_ferr <= ~rxd_q;
            rx_ph <= 2'b00;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // transmitter
  // ----------------------------------------------------------------
  reg tx_go; // one-cycle load request from the sequencer
  reg [7:0] tx_data; // byte to send
  reg [9:0] tx_sh; // stop, data, start
  reg [3:0] tx_n; // bits left, zero when idle
  reg [15:0] tx_cnt; // cycles left in this bit
  reg tx_tog; // fraction phase

  // 8N1 transmitter; acks never overlap since the controller waits
  always @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      TXD <= 1'b1;
      tx_sh <= 10'h3FF;
      tx_n <= 4'h0;
      tx_cnt <= 16'h0000;
      tx_tog <= 1'b0;
    end
    else if (tx_go)
    begin
      TXD <= 1'b0;
      tx_sh <= {1'b1, tx_data, 1'b0};
      tx_n <= 4'hA;
      tx_tog <= 1'b0;
      tx_cnt <= bit_len(BAUD_DIVIDER_CONTROL, BAUD_FRACTION_ADJUST, 1'b0);
    end
    else if (tx_n != 4'h0)
    begin
      if (tx_cnt != 16'h0000)
        tx_cnt <= tx_cnt - 16'h0001;
      else
      begin
        tx_sh <= {1'b1, tx_sh[9:1]};
        TXD <= tx_sh[1];
        tx_n <= tx_n - 4'h1;
        tx_tog <= ~tx_tog;
        tx_cnt <= bit_len(BAUD_DIVIDER_CONTROL, BAUD_FRACTION_ADJUST, ~tx_tog);
      end
    end
  end

  // ----------------------------------------------------------------
  // sequencer state
  // ----------------------------------------------------------------
  reg [3:0] st; // sequencer state
  reg [17:0] meas; // low time of start bit plus bit 0, or quiet time
  reg [3:0] cmd_hi; // upper nibble of the last command byte
  reg is_prot; // password stage belongs to protect-set
  reg [3:0] idx; // byte index inside a field
  reg [7:0] sum; // running field sum
  reg ferr; // any receive error in the field
  reg pw_bad; // any password byte mismatched
  reg [47:0] hdr; // address and count, shifted in msb first
  reg [31:0] waddr; // next ram address
  reg [15:0] left; // payload bytes still to come
  reg strap_done; // protection straps captured
  reg ram_we; // ram write strobe
  reg [`SBRL_RAM_AW-1:0] ram_wa; // ram write index
  reg [7:0] ram_wd; // ram write byte
  wire [7:0] sum_all = sum + rx_byte;
  wire err_all = ferr | rx_ferr;
  wire prot_any = RD_PROT | WR_PROT;
  wire [31:0] ram_off = waddr - `SBRL_RAM_BASE;
  wire in_win = (waddr >= `SBRL_RAM_BASE) && (waddr <= `SBRL_RAM_END);

  // ----------------------------------------------------------------
  // boot sequencer
  // ----------------------------------------------------------------
  always @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      st <= ST_SYNC;
      meas <= 18'h00000;
      cmd_hi <= 4'h0;
      is_prot <= 1'b0;
      idx <= 4'h0;
      sum <= 8'h00;
      ferr <= 1'b0;
      pw_bad <= 1'b0;
      hdr <= 48'h000000000000;
      waddr <= 32'h00000000;
      left <= 16'h0000;
      strap_done <= 1'b0;
      ram_we <= 1'b0;
      ram_wa <= {`SBRL_RAM_AW{1'b0}};
      ram_wd <= 8'h00;
      tx_go <= 1'b0;
      tx_data <= 8'h00;
      FLASH_PWD_IDX <= 4'h0;
      ERASE_ALL <= 1'b0;
      RD_PROT <= 1'b0;
      WR_PROT <= 1'b0;
      BAUD_DIVIDER_CONTROL <= 16'h0000;
      BAUD_FRACTION_ADJUST <= 1'b0;
      RECEIVER_ENABLE_BIT <= 1'b0;
      HALTED <= 1'b0;
      JUMP <= 1'b0;
      JUMP_ADDR <= 32'h00000000;
    end
    else
    begin
      tx_go <= 1'b0;
      ERASE_ALL <= 1'b0;
      JUMP <= 1'b0;
      ram_we <= 1'b0;
      // protection comes from the straps once, after reset release
      if (!strap_done)
      begin
        strap_done <= 1'b1;
        RD_PROT <= RD_PROT_STRAP;
        WR_PROT <= WR_PROT_STRAP;
      end
      case (st)
        ST_SYNC:
        begin
          // receiver stays off while the sync byte is timed
          if (rx_fall)
          begin
            meas <= 18'h00001; // the cycle that shows the edge is already low
            st <= ST_MEAS;
          end
        end
        ST_MEAS:
        begin
          // start bit and bit 0 of 86H are low: two bit times
          if (meas[16:0] == `SBRL_MEAS_MAX)
          begin
            HALTED <= 1'b1;
            st <= ST_HALT;
          end
          else if (rxd_q)
          begin
            if (meas[16:1] < `SBRL_BIT_MIN)
            begin
              HALTED <= 1'b1; // too fast to divide down
              st <= ST_HALT;
            end
            else
            begin
              BAUD_DIVIDER_CONTROL <= meas[16:1];
              BAUD_FRACTION_ADJUST <= meas[0];
              meas <= 18'h00000;
              st <= ST_QUIET;
            end
          end
          else
            meas <= meas + 18'h00001;
        end
        ST_QUIET:
        begin
          // wait out the sync frame: three idle bit times exceed any
          // high run inside 86H, so the stop bit is surely past
          if (!rxd_q)
            meas <= 18'h00000;
          else if (meas >= {2'b00, BAUD_DIVIDER_CONTROL} + {1'b0, BAUD_DIVIDER_CONTROL, 1'b0})
          begin
            RECEIVER_ENABLE_BIT <= 1'b1; // before the ack is loaded
            st <= ST_ACKS;
          end
          else
            meas <= meas + 18'h00001;
        end
        ST_ACKS:
        begin
          tx_go <= 1'b1;
          tx_data <= `SBRL_SYNC;
          st <= ST_CMD;
        end
        ST_CMD:
        begin
          if (rx_done)
          begin
            tx_go <= 1'b1;
            idx <= 4'h0;
            sum <= 8'h00;
            ferr <= 1'b0;
            pw_bad <= 1'b0;
            FLASH_PWD_IDX <= 4'h0;
            if (rx_ferr)
              tx_data <= ack_of(cmd_hi, `SBRL_NIB_COMM);
            else
            begin
              cmd_hi <= rx_byte[7:4];
              case (rx_byte)
                `SBRL_CMD_LOAD:
                begin
                  if (prot_any)
                    tx_data <= ack_of(rx_byte[7:4], `SBRL_NIB_PROT);
                  else
                  begin
                    tx_data <= rx_byte;
                    is_prot <= 1'b0;
                    st <= ST_PWD;
                  end
                end
                `SBRL_CMD_PROT:
                begin
                  tx_data <= rx_byte;
                  is_prot <= 1'b1;
                  st <= ST_PWD;
                end
                `SBRL_CMD_ERASE:
                begin
                  // no password stage on this path
                  tx_data <= rx_byte;
                  ERASE_ALL <= 1'b1;
                  RD_PROT <= 1'b0;
                  WR_PROT <= 1'b0;
                end
                `SBRL_CMD_SUM, `SBRL_CMD_INFO:
                  tx_data <= rx_byte; // echoed; their frames live elsewhere
                default:
                  tx_data <= ack_of(cmd_hi, `SBRL_NIB_BAD); // previous nibble kept
              endcase
            end
          end
        end
        ST_PWD:
        begin
          // flash byte at the current index is steady since last byte
          if (rx_done)
          begin
            sum <= sum_all;
            ferr <= err_all;
            if (rx_byte != FLASH_PWD_DATA)
              pw_bad <= 1'b1;
            if (idx == `SBRL_PWD_LAST)
              st <= ST_PCHK;
            else
            begin
              idx <= idx + 4'h1;
              FLASH_PWD_IDX <= idx + 4'h1;
            end
          end
        end
        ST_PCHK:
        begin
          if (rx_done)
          begin
            tx_go <= 1'b1;
            st <= ST_CMD;
            // receive error first, then checksum, then password
            if (err_all)
              tx_data <= ack_of(cmd_hi, `SBRL_NIB_COMM);
            else if (sum_all != `SBRL_SUM_OK)
              tx_data <= ack_of(cmd_hi, `SBRL_NIB_BAD);
            else if (pw_bad)
              tx_data <= ack_of(cmd_hi, `SBRL_NIB_BAD);
            else
            begin
              tx_data <= ack_of(cmd_hi, `SBRL_NIB_OK);
              if (is_prot)
              begin
                RD_PROT <= 1'b1;
                WR_PROT <= 1'b1;
              end
              else
              begin
                idx <= 4'h0;
                sum <= 8'h00;
                ferr <= 1'b0;
                st <= ST_HDR;
              end
            end
          end
        end
        ST_HDR:
        begin
          // address msb first, then count high first
          if (rx_done)
          begin
            hdr <= {hdr[39:0], rx_byte};
            sum <= sum_all;
            ferr <= err_all;
            if (idx == `SBRL_HDR_LAST)
              st <= ST_HCHK;
            else
              idx <= idx + 4'h1;
          end
        end
        ST_HCHK:
        begin
          if (rx_done)
          begin
            tx_go <= 1'b1;
            st <= ST_CMD;
            if (err_all)
              tx_data <= ack_of(cmd_hi, `SBRL_NIB_COMM);
            else if (sum_all != `SBRL_SUM_OK)
              tx_data <= ack_of(cmd_hi, `SBRL_NIB_BAD);
            else
            begin
              tx_data <= ack_of(cmd_hi, `SBRL_NIB_OK);
              JUMP_ADDR <= hdr[47:16];
              waddr <= hdr[47:16];
              left <= hdr[15:0];
              sum <= 8'h00;
              ferr <= 1'b0;
              st <= (hdr[15:0] == 16'h0000) ? ST_DCHK : ST_DATA;
            end
          end
        end
        ST_DATA:
        begin
          // bytes outside the user window are dropped, not wrapped
          if (rx_done)
          begin
            ram_we <= in_win;
            ram_wa <= ram_off[`SBRL_RAM_AW-1:0];
            ram_wd <= rx_byte;
            waddr <= waddr + 32'h00000001;
            left <= left - 16'h0001;
            sum <= sum_all;
            ferr <= err_all;
            if (left == 16'h0001)
              st <= ST_DCHK;
          end
        end
        ST_DCHK:
        begin
          if (rx_done)
          begin
            tx_go <= 1'b1;
            st <= ST_CMD;
            if (err_all)
              tx_data <= ack_of(cmd_hi, `SBRL_NIB_COMM);
            else if (sum_all != `SBRL_SUM_OK)
              tx_data <= ack_of(cmd_hi, `SBRL_NIB_BAD);
            else
            begin
              tx_data <= ack_of(cmd_hi, `SBRL_NIB_OK);
              JUMP <= 1'b1;
              st <= ST_RUN;
            end
          end
        end
        ST_RUN:
          st <= ST_RUN; // loaded code owns the machine now
        ST_HALT:
          st <= ST_HALT; // silent until the next reset
        default:
          st <= ST_SYNC;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // programmer access gate
  // ----------------------------------------------------------------
  // grants follow requests by one cycle, masked by protection
  always @(posedge CLK_SYS or posedge RST)
  begin
    if (RST)
    begin
      PGM_RD_GRANT <= 1'b0;
      PGM_WR_GRANT <= 1'b0;
    end
    else
    begin
      PGM_RD_GRANT <= PGM_RD_REQ & ~RD_PROT;
      PGM_WR_GRANT <= PGM_WR_REQ & ~WR_PROT;
    end
  end

  // ----------------------------------------------------------------
  // user ram
  // ----------------------------------------------------------------
  sbrl_ram u_ram (
    .clk(CLK_SYS),
    .we(ram_we),
    .waddr(ram_wa),
    .wdata(ram_wd),
    .raddr(CPU_RD_ADDR),
    .rdata(CPU_RD_DATA)
  );
endmodule // sbrl_loader

// >>> sim/sbrl_loader_assertions.sv
`timescale 1ns/1ps
`include "sbrl_map.vh"
// ----
// port checks for the loader
// ----
module sbrl_loader_assertions (
  input wire CLK_SYS,
  input wire RST,
  input wire TXD,
  input wire PGM_RD_REQ,
  input wire PGM_WR_REQ,
  input wire PGM_RD_GRANT,
  input wire PGM_WR_GRANT,
  input wire ERASE_ALL,
  input wire RD_PROT,
  input wire WR_PROT,
  input wire [15:0] BAUD_DIVIDER_CONTROL,
  input wire RECEIVER_ENABLE_BIT,
  input wire HALTED,
  input wire JUMP
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  // grants follow the protection seen one cycle earlier
  a_read_gate: assert property (PGM_RD_REQ |=> PGM_RD_GRANT == !$past(RD_PROT))
    else $error("read grant wrong");
  a_write_gate: assert property (PGM_WR_REQ |=> PGM_WR_GRANT == !$past(WR_PROT))
    else $error("write grant wrong");
  // erase wipes both protections at once
  a_erase_clears: assert property (ERASE_ALL |-> ##[0:1] (!RD_PROT && !WR_PROT))
    else $error("erase left protection");
  a_erase_pulse: assert property (ERASE_ALL |=> !ERASE_ALL)
    else $error("erase pulse too long");
  // after boot only protect-set raises protection, and both together
  a_prot_paired: assert property ($past(RECEIVER_ENABLE_BIT) && $rose(RD_PROT || WR_PROT)
    |-> RD_PROT && WR_PROT)
    else $error("protection not paired");
  a_halt_silent: assert property (HALTED |-> TXD && !RECEIVER_ENABLE_BIT)
    else $error("halted device talks");
  // no byte leaves before the receiver is on and a sane divider is set
  a_ack_enabled: assert property ($fell(TXD)
    |-> RECEIVER_ENABLE_BIT && BAUD_DIVIDER_CONTROL >= `SBRL_BIT_MIN)
    else $error("transmit before setup");
  a_jump_pulse: assert property (JUMP |-> RECEIVER_ENABLE_BIT ##1 !JUMP)
    else $error("bad jump pulse");
  c_jump: cover property (JUMP);
  c_erase: cover property (ERASE_ALL);
  c_halt: cover property ($rose(HALTED));
  c_prot: cover property ($rose(WR_PROT));
endmodule // sbrl_loader_assertions

// >>> sim/sbrl_host_model.sv
`timescale 1ns/1ps
// ----
// controller end of the serial link
// ----
module sbrl_host_model (
  input wire CLK_SYS,
  output reg RXD,
  input wire TXD
);
  integer per = 32; // cycles per bit
  reg lost = 1'b0; // reply missing or stop bit low
  initial RXD = 1'b1; // idle high
  // 8N1 frame, lsb first; fe forces a low stop bit
  task send(input [7:0] b, input fe);
    integer i;
    begin
      for (i = 0; i < 10; i = i + 1)
      begin
        RXD <= (i == 0) ? 1'b0 : (i == 9) ? !fe : b[i-1];
        repeat (per) @(posedge CLK_SYS);
      end
      if (fe)
      begin
        RXD <= 1'b1;
        repeat (per) @(posedge CLK_SYS);
      end
    end
  endtask
  // bounded wait for a start bit, then sample mid-bit
  task recv(output [7:0] b);
    integer n;
    begin
      lost = 1'b1;
      b = 8'h00;
      for (n = 0; n < 30000 && lost; n = n + 1)
      begin
        @(posedge CLK_SYS);
        if (TXD === 1'b0)
          lost = 1'b0;
      end
      repeat (per / 2) @(posedge CLK_SYS);
      for (n = 0; n < 9; n = n + 1)
      begin
        repeat (per) @(posedge CLK_SYS);
        if (n < 8)
          b[n] = TXD;
        else if (TXD !== 1'b1)
          lost = 1'b1; // framing of reply
      end
    end
  endtask
endmodule // sbrl_host_model

// >>> sim/test_serial_boot_ram_loader.sv
`timescale 1ns/1ps
`include "sbrl_map.vh"
module test_serial_boot_ram_loader;
  reg CLK_SYS = 1'b0;
  reg RST = 1'b1;
  reg RD_PROT_STRAP = 1'b1; // boots read-protected
  reg WR_PROT_STRAP = 1'b0;
  reg [7:0] FLASH_PWD_DATA = 8'h00;
  reg PGM_RD_REQ = 1'b0;
  reg PGM_WR_REQ = 1'b0;
  reg [`SBRL_RAM_AW-1:0] CPU_RD_ADDR = 13'h0000;
  wire RXD, TXD, PGM_RD_GRANT, PGM_WR_GRANT, ERASE_ALL, RD_PROT, WR_PROT;
  wire BAUD_FRACTION_ADJUST, RECEIVER_ENABLE_BIT, HALTED, JUMP;
  wire [3:0] FLASH_PWD_IDX;
  wire [15:0] BAUD_DIVIDER_CONTROL;
  wire [31:0] JUMP_ADDR;
  wire [7:0] CPU_RD_DATA;
  integer miscompares = 0;
  integer checks_done = 0;
  integer jumps = 0;
  integer i;
  reg [15:0] n;
  reg [31:0] seed, addr;
  reg [7:0] r;
  reg [7:0] pw[$], bad[$], hdr[$], pl[$];
  sbrl_loader dut (.CLK_SYS(CLK_SYS), .RST(RST), .RXD(RXD), .TXD(TXD),
    .RD_PROT_STRAP(RD_PROT_STRAP), .WR_PROT_STRAP(WR_PROT_STRAP),
    .FLASH_PWD_IDX(FLASH_PWD_IDX), .FLASH_PWD_DATA(FLASH_PWD_DATA),
    .PGM_RD_REQ(PGM_RD_REQ), .PGM_WR_REQ(PGM_WR_REQ), .PGM_RD_GRANT(PGM_RD_GRANT),
    .PGM_WR_GRANT(PGM_WR_GRANT), .ERASE_ALL(ERASE_ALL), .RD_PROT(RD_PROT), .WR_PROT(WR_PROT),
    .BAUD_DIVIDER_CONTROL(BAUD_DIVIDER_CONTROL), .BAUD_FRACTION_ADJUST(BAUD_FRACTION_ADJUST),
    .RECEIVER_ENABLE_BIT(RECEIVER_ENABLE_BIT), .HALTED(HALTED), .JUMP(JUMP),
    .JUMP_ADDR(JUMP_ADDR), .CPU_RD_ADDR(CPU_RD_ADDR), .CPU_RD_DATA(CPU_RD_DATA));
  sbrl_host_model host (.CLK_SYS(CLK_SYS), .RXD(RXD), .TXD(TXD));
  initial forever #2.5 CLK_SYS = ~CLK_SYS;
  function [7:0] pwd_byte(input [3:0] k);
    pwd_byte = 8'hA5 + {k, 4'h3};
  endfunction
  // flash password store, random programmer traffic, jump counter
  always @(posedge CLK_SYS)
  begin
    FLASH_PWD_DATA <= pwd_byte(FLASH_PWD_IDX);
    {PGM_RD_REQ, PGM_WR_REQ} <= 2'($urandom);
    if (JUMP === 1'b1)
      jumps <= jumps + 1;
  end
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp)
      begin
        miscompares = miscompares + 1;
        $display("FAIL %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  // send one byte and compare the reply; a missing reply ends the run
  task ack(input [7:0] b, input fe, input [7:0] exp);
    begin
      fork
        host.send(b, fe);
        host.recv(r);
      join
      if (host.lost)
      begin
        miscompares = miscompares + 1;
        $display("FAIL %0t no reply", $time);
        give_verdict;
      end
      else
        chk(r, exp);
    end
  endtask
  // field bytes back to back, then checksum plus skew
  task field(input reg [7:0] q[$], input [7:0] skew, input [7:0] exp);
    reg [7:0] s;
    begin
      s = 8'h00;
      foreach (q[k])
      begin
        host.send(q[k], 1'b0);
        s = s + q[k];
      end
      ack(8'h00 - s + skew, 1'b0, exp);
    end
  endtask
  initial
  begin
    seed = $urandom(32'h9FE3);
    for (i = 0; i < 12; i = i + 1)
      pw.push_back(pwd_byte(i[3:0]));
    bad = pw;
    bad[11] = ~bad[11];
    repeat (3) @(posedge CLK_SYS);
    RST <= 1'b0;
    repeat (2) @(posedge CLK_SYS);
    ack(`SBRL_SYNC, 1'b0, `SBRL_SYNC);
    chk(RECEIVER_ENABLE_BIT, 1);
    chk(BAUD_DIVIDER_CONTROL >= 31 && BAUD_DIVIDER_CONTROL <= 33, 1);
    chk(BAUD_FRACTION_ADJUST, 0);
    $display("test sync done");
    ack(8'h10, 1'b0, 8'h16);
    ack(8'h57, 1'b0, 8'h11);
    ack(8'h10, 1'b1, 8'h58);
    ack(8'h20, 1'b0, 8'h20);
    ack(8'h30, 1'b0, 8'h30);
    $display("test command done");
    ack(8'h40, 1'b0, 8'h40);
    chk({RD_PROT, WR_PROT}, 0);
    ack(8'h60, 1'b0, 8'h60);
    field(bad, 8'h00, 8'h61);
    chk({RD_PROT, WR_PROT}, 0);
    ack(8'h60, 1'b0, 8'h60);
    field(pw, 8'h00, 8'h60);
    chk({RD_PROT, WR_PROT}, 3);
    ack(8'h10, 1'b0, 8'h16);
    ack(8'h40, 1'b0, 8'h40);
    chk({RD_PROT, WR_PROT}, 0);
    $display("test protect done");
    ack(8'h10, 1'b0, 8'h10);
    field(pw, 8'h01, 8'h11);
    ack(8'h10, 1'b0, 8'h10);
    field(bad, 8'h00, 8'h11);
    $display("test password done");
    n = 16'(1 + $urandom % 12);
    addr = 32'h00001000 + ($urandom % 32'h00001C00);
    hdr = {addr[31:24], addr[23:16], addr[15:8], addr[7:0], n[15:8], n[7:0]};
    ack(8'h10, 1'b0, 8'h10);
    field(pw, 8'h00, 8'h10);
    field(hdr, 8'hFF, 8'h11);
    ack(8'h10, 1'b0, 8'h10);
    field(pw, 8'h00, 8'h10);
    field(hdr, 8'h00, 8'h10);
    for (i = 0; i < n; i = i + 1)
      pl.push_back(8'($urandom));
    field(pl, 8'h00, 8'h10);
    chk(jumps, 1);
    chk(JUMP_ADDR, addr);
    for (i = 0; i < n; i = i + 1)
    begin
      CPU_RD_ADDR <= 13'(addr - 32'h00001000 + i);
      repeat (2) @(posedge CLK_SYS);
      chk(CPU_RD_DATA, pl[i]);
    end
    $display("test load done");
    RST <= 1'b1;
    repeat (3) @(posedge CLK_SYS);
    RST <= 1'b0;
    repeat (2) @(posedge CLK_SYS);
    host.per = 8;
    host.send(`SBRL_SYNC, 1'b0);
    host.recv(r);
    chk(host.lost, 1);
    chk(HALTED, 1);
    $display("test halt done");
    give_verdict;
  end
endmodule // test_serial_boot_ram_loader
bind sbrl_loader sbrl_loader_assertions chk_i (.CLK_SYS(CLK_SYS), .RST(RST), .TXD(TXD),
  .PGM_RD_REQ(PGM_RD_REQ), .PGM_WR_REQ(PGM_WR_REQ), .PGM_RD_GRANT(PGM_RD_GRANT),
  .PGM_WR_GRANT(PGM_WR_GRANT), .ERASE_ALL(ERASE_ALL), .RD_PROT(RD_PROT), .WR_PROT(WR_PROT),
  .BAUD_DIVIDER_CONTROL(BAUD_DIVIDER_CONTROL), .RECEIVER_ENABLE_BIT(RECEIVER_ENABLE_BIT),
  .HALTED(HALTED), .JUMP(JUMP));
